// file: core/dfs_pkg.sv
// frame statistics counter constants: word indices, widths, counts
// assumes a 32-bit wishbone slave whose byte address is four times the index
package dfs_pkg;
  localparam int unsigned ADR_W = 12;                        // byte address width
  localparam int unsigned IDX_W = 10;                        // word index width
  localparam int unsigned CNT_W = 16;                        // counter width
  localparam int unsigned NCH   = 3;                         // counted channels
  // word indices of the registers
  localparam logic [IDX_W-1:0] IDX_UPPER_RX_HI   = 10'h275;
  localparam logic [IDX_W-1:0] IDX_UPPER_RX_LO   = 10'h276;
  localparam logic [IDX_W-1:0] IDX_LOWER_RX_HI   = 10'h277;
  localparam logic [IDX_W-1:0] IDX_LOWER_RX_LO   = 10'h278;
  localparam logic [IDX_W-1:0] IDX_UPPER_TX_HI   = 10'h279;
  localparam logic [IDX_W-1:0] IDX_UPPER_TX_LO   = 10'h27a;
  localparam logic [IDX_W-1:0] IDX_LOWER_TRIGGER = 10'h290;
  localparam logic [IDX_W-1:0] IDX_UPPER_TRIGGER = 10'h291;
  // channel numbers inside the counter array
  localparam int unsigned CH_UPPER_RX = 0;
  localparam int unsigned CH_LOWER_RX = 1;
  localparam int unsigned CH_UPPER_TX = 2;
  // saturation flag bit positions in the trigger registers
  localparam int unsigned FLAG_LOWER_RX_SAT = 0;
  localparam int unsigned FLAG_UPPER_RX_SAT = 0;
  localparam int unsigned FLAG_UPPER_TX_SAT = 1;
  // counter values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
  localparam logic [31:0]      DAT_ZERO = 32'h0000_0000;
endpackage

// file: core/dfs_frame_stats.sv
// daisy-chain frame statistics counters with a classic wishbone slave
// assumes frame event inputs are one-cycle pulses from logic on clk_i
// Function
// - count valid lower-port received response frames
// - lower receive counter holds at full scale
// - lower trigger read snapshots, then clears the lower receive counter
// - count upper-port transmitted response frames
// - upper transmit counter holds at full scale
// - upper trigger read snapshots, then clears both upper counters
// - upper receive counts error-free frames, saturating
// - upper receive counts only correct-crc frames
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module dfs_frame_stats
(
  input  wire logic        clk_i,               // 100 MHz clock
  input  wire logic        rst_i,               // synchronous reset, active high
  input  wire logic        wb_cyc_i,            // wishbone cycle
  input  wire logic        wb_stb_i,            // wishbone strobe
  input  wire logic        wb_we_i,             // wishbone write enable
  input  wire logic [11:0] wb_adr_i,            // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,            // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,            // wishbone write data
  output logic      [31:0] wb_dat_o,            // wishbone read data
  output logic             wb_ack_o,            // wishbone acknowledge
  input  wire logic        lower_rx_valid_i,    // valid response frame received, lower chain port
  input  wire logic        upper_rx_frame_i,    // frame received, upper chain port
  input  wire logic        upper_rx_err_i,      // that frame had a receive error
  input  wire logic        upper_rx_crc_ok_i,   // that frame carried a correct crc
  input  wire logic        upper_tx_frame_i     // response frame sent, upper chain port
);

  logic                        req;             // new request, not yet answered
  logic                        rd_req;          // new read request
  logic [dfs_pkg::IDX_W-1:0]   idx;             // word index of the access
  logic                        snap_lower;      // lower trigger register being read
  logic                        snap_upper;      // upper trigger register being read
  logic [dfs_pkg::NCH-1:0]     ev;              // qualifying frame per channel
  logic [dfs_pkg::NCH-1:0]     snap;            // snapshot strobe per channel
  logic [dfs_pkg::CNT_W-1:0]   cnt    [dfs_pkg::NCH];  // live counters
  logic [dfs_pkg::CNT_W-1:0]   shadow [dfs_pkg::NCH];  // values software sees
  logic [31:0]                 next_dat;        // read data for this access

  // a read of a trigger word is the only bus event with a side effect; the
  // strobe is cut by the registered ack so a held request snapshots only once
  // request decode; write data and selects are ignored, no register is writable
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_req     = req && !wb_we_i;
  assign idx        = wb_adr_i[dfs_pkg::ADR_W-1:dfs_pkg::ADR_W-dfs_pkg::IDX_W];  // byte lanes ignored
  assign snap_lower = rd_req && (idx == dfs_pkg::IDX_LOWER_TRIGGER);
  assign snap_upper = rd_req && (idx == dfs_pkg::IDX_UPPER_TRIGGER);

  // frame qualification per channel
  assign ev[dfs_pkg::CH_UPPER_RX] = upper_rx_frame_i && !upper_rx_err_i && upper_rx_crc_ok_i;
  assign ev[dfs_pkg::CH_LOWER_RX] = lower_rx_valid_i;
  assign ev[dfs_pkg::CH_UPPER_TX] = upper_tx_frame_i;
  assign snap[dfs_pkg::CH_UPPER_RX] = snap_upper;
  assign snap[dfs_pkg::CH_LOWER_RX] = snap_lower;
  assign snap[dfs_pkg::CH_UPPER_TX] = snap_upper;

  // one saturating counter and snapshot register per channel
  for (genvar c = 0; c < dfs_pkg::NCH; c++)
  begin : g_ch
    // live counter; a frame in the clearing cycle is kept as a count of one,
    // so no frame falls between two snapshot periods
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cnt[c] <= dfs_pkg::CNT_ZERO;
      else if (snap[c])
        cnt[c] <= ev[c] ? dfs_pkg::CNT_ONE : dfs_pkg::CNT_ZERO;
      else if (ev[c] && cnt[c] != dfs_pkg::CNT_MAX)
        cnt[c] <= cnt[c] + dfs_pkg::CNT_ONE;
    end

    // snapshot taken at the trigger read, all channels of a port at once
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        shadow[c] <= dfs_pkg::CNT_ZERO;
      else if (snap[c])
        shadow[c] <= cnt[c];
    end

    // counter steps by exactly one on a qualifying frame
    a_cnt_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
      (ev[c] && !snap[c] && cnt[c] != dfs_pkg::CNT_MAX) |=> (cnt[c] == $past(cnt[c]) + dfs_pkg::CNT_ONE))
      else $error("counter did not step by one");
    // full scale holds against further frames
    a_cnt_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt[c] == dfs_pkg::CNT_MAX && !snap[c]) |=> (cnt[c] == dfs_pkg::CNT_MAX))
      else $error("counter left full scale");
    // snapshot carries the old count, counter restarts
    a_snap_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      snap[c] |=> (shadow[c] == $past(cnt[c])) && (cnt[c] == ($past(ev[c]) ? dfs_pkg::CNT_ONE : dfs_pkg::CNT_ZERO)))
      else $error("snapshot or clear wrong");
    // no event and no snapshot leaves counter alone
    a_cnt_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ev[c] && !snap[c]) |=> $stable(cnt[c]))
      else $error("counter moved without a frame");
  end

  // read data multiplexer; counter registers return the snapshot, trigger
  // registers return live saturation flags, unmapped words read zero
  always_comb
  begin
    next_dat = dfs_pkg::DAT_ZERO;
    unique case (idx)
      dfs_pkg::IDX_UPPER_RX_HI:   next_dat[7:0] = shadow[dfs_pkg::CH_UPPER_RX][15:8];
      dfs_pkg::IDX_UPPER_RX_LO:   next_dat[7:0] = shadow[dfs_pkg::CH_UPPER_RX][7:0];
      dfs_pkg::IDX_LOWER_RX_HI:   next_dat[7:0] = shadow[dfs_pkg::CH_LOWER_RX][15:8];
      dfs_pkg::IDX_LOWER_RX_LO:   next_dat[7:0] = shadow[dfs_pkg::CH_LOWER_RX][7:0];
      dfs_pkg::IDX_UPPER_TX_HI:   next_dat[7:0] = shadow[dfs_pkg::CH_UPPER_TX][15:8];
      dfs_pkg::IDX_UPPER_TX_LO:   next_dat[7:0] = shadow[dfs_pkg::CH_UPPER_TX][7:0];
      // trigger flags show the live counters, sampled before the clear lands
      dfs_pkg::IDX_LOWER_TRIGGER:
      begin
        next_dat[dfs_pkg::FLAG_LOWER_RX_SAT] = (cnt[dfs_pkg::CH_LOWER_RX] == dfs_pkg::CNT_MAX);
      end
      dfs_pkg::IDX_UPPER_TRIGGER:
      begin
        next_dat[dfs_pkg::FLAG_UPPER_RX_SAT] = (cnt[dfs_pkg::CH_UPPER_RX] == dfs_pkg::CNT_MAX);
        next_dat[dfs_pkg::FLAG_UPPER_TX_SAT] = (cnt[dfs_pkg::CH_UPPER_TX] == dfs_pkg::CNT_MAX);
      end
      default:                    next_dat = dfs_pkg::DAT_ZERO;
    endcase
    if (wb_we_i)
      next_dat = dfs_pkg::DAT_ZERO;   // writes are acknowledged and dropped
  end

  // a registered ack costs one cycle per access but keeps the bus outputs
  // straight from flip-flops; counter polling is slow enough to afford it
  // acknowledge one cycle after the request, then drop for one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // read data register, captured with the acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= dfs_pkg::DAT_ZERO;
    else if (req)
      wb_dat_o <= next_dat;
  end

  // every request gets its answer on the next edge
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  // acknowledge is a single cycle
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");
  // transmit high byte read returns the snapshot high byte
  a_read_tx_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_UPPER_TX_HI) |=>
      (wb_ack_o && wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_UPPER_TX][15:8])}))
    else $error("transmit high byte read wrong");
  // lower low byte read returns the snapshot low byte
  a_read_lower_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_LOWER_RX_LO) |=>
      (wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_LOWER_RX][7:0])}))
    else $error("lower low byte read wrong");
  // a bad upper frame is never counted
  a_upper_bad_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    (upper_rx_frame_i && (upper_rx_err_i || !upper_rx_crc_ok_i) && !snap_upper) |=>
      $stable(cnt[dfs_pkg::CH_UPPER_RX]))
    else $error("bad upper frame counted");
  // writes leave all snapshots untouched
  a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i) |=> ($stable(shadow[0]) && $stable(shadow[1]) && $stable(shadow[2])))
    else $error("write changed a register");
  // a lower trigger read leaves the upper transmit snapshot alone
  a_port_separate: assert property (@(posedge clk_i) disable iff (rst_i)
    snap_lower |=> $stable(shadow[dfs_pkg::CH_UPPER_TX]))
    else $error("lower trigger touched upper port");
  // an upper trigger read leaves the lower snapshot alone
  a_port_separate_up: assert property (@(posedge clk_i) disable iff (rst_i)
    snap_upper |=> $stable(shadow[dfs_pkg::CH_LOWER_RX]))
    else $error("upper trigger touched lower port");
  // both upper counters land in their snapshots in the same cycle
  a_upper_snap_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    snap_upper |=> (shadow[dfs_pkg::CH_UPPER_RX] == $past(cnt[dfs_pkg::CH_UPPER_RX]))
      && (shadow[dfs_pkg::CH_UPPER_TX] == $past(cnt[dfs_pkg::CH_UPPER_TX])))
    else $error("upper snapshots not taken together");
  // upper receive high byte read returns the snapshot high byte
  a_read_upper_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_UPPER_RX_HI) |=>
      (wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_UPPER_RX][15:8])}))
    else $error("upper receive high byte read wrong");
  // upper receive low byte read returns the snapshot low byte
  a_read_upper_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_UPPER_RX_LO) |=>
      (wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_UPPER_RX][7:0])}))
    else $error("upper receive low byte read wrong");
  // lower high byte read returns the snapshot high byte
  a_read_lower_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_LOWER_RX_HI) |=>
      (wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_LOWER_RX][15:8])}))
    else $error("lower high byte read wrong");
  // transmit low byte read returns the snapshot low byte
  a_read_tx_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_UPPER_TX_LO) |=>
      (wb_dat_o == {24'h00_0000, $past(shadow[dfs_pkg::CH_UPPER_TX][7:0])}))
    else $error("transmit low byte read wrong");
  // lower trigger read reports saturation as it stood before the clear
  a_lower_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_LOWER_TRIGGER) |=>
      (wb_dat_o == {31'h0, ($past(cnt[dfs_pkg::CH_LOWER_RX]) == dfs_pkg::CNT_MAX)}))
    else $error("lower saturation flag wrong");
  // upper trigger read reports both saturation flags before the clear
  a_upper_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && idx == dfs_pkg::IDX_UPPER_TRIGGER) |=>
      (wb_dat_o == {30'h0, ($past(cnt[dfs_pkg::CH_UPPER_TX]) == dfs_pkg::CNT_MAX),
                    ($past(cnt[dfs_pkg::CH_UPPER_RX]) == dfs_pkg::CNT_MAX)}))
    else $error("upper saturation flags wrong");
  // a write is answered with zero data
  a_write_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i) |=> (wb_dat_o == dfs_pkg::DAT_ZERO))
    else $error("write returned data");
  // read data stands until the next request is taken
  a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> $stable(wb_dat_o))
    else $error("read data changed without a request");

endmodule

// file: sim/dfs_chain_peer.sv
// chain neighbour model: drives frame pulses onto the event lines
// assumes a one-cycle go while busy is low
`timescale 1ns/1ps
module dfs_chain_peer
(
  input  wire logic        clk_i,  // bench clock
  input  wire logic        go_i,   // start a burst
  input  wire logic [16:0] n_i,    // good frames per channel
  input  wire logic [2:0]  ch_i,   // upper tx, upper rx, lower rx
  input  wire logic        bad_i,  // add faulty upper frames
  input  wire logic [1:0]  gap_i,  // idle cycles after a frame
  output logic             busy_o, // burst running
  output logic [4:0]       ev_o    // lower rx, upper rx, err, crc ok, upper tx
);
  int k;
  // qualifiers toggle when idle, so a count that ignores the strobe shows up
  task idle(input int c);
    repeat (c)
    begin
      ev_o <= {2'b00, ~ev_o[2:1], 1'b0};
      @(posedge clk_i);
    end
  endtask
  // one burst per go; gap 0 gives back-to-back frames
  initial
  begin
    busy_o <= 1'b0;
    ev_o   <= 5'h00;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        busy_o <= 1'b1;
        for (k = 0; k < n_i; k++)
        begin
          ev_o <= {ch_i[0], ch_i[1], 1'b0, ch_i[1], ch_i[2]};
          @(posedge clk_i);
          if (bad_i)
          begin
            ev_o <= 5'h0e; // errored frame with good crc
            @(posedge clk_i);
            ev_o <= 5'h08; // clean frame with bad crc
            @(posedge clk_i);
          end
          idle(gap_i);
        end
        idle(1);
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// file: sim/testbench.sv
// self-checking bench for the frame statistics counters
// assumes dfs_pkg, the design and the neighbour model are compiled first
`timescale 1ns/1ps
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, ack, go, pb, busy;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, e;
  logic [16:0] pn;
  logic [2:0]  pc;
  logic [1:0]  pg;
  logic [4:0]  ev;
  logic [31:0] q[$];                     // expected read data, oldest first
  int          err_count, n_tests, cycles, seed = 87194;
  dfs_frame_stats dfs_frame_stats_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lower_rx_valid_i(ev[4]),
    .upper_rx_frame_i(ev[3]), .upper_rx_err_i(ev[2]), .upper_rx_crc_ok_i(ev[1]), .upper_tx_frame_i(ev[0]));
  dfs_chain_peer dfs_chain_peer_i (.clk_i(clk_i), .go_i(go), .n_i(pn), .ch_i(pc), .bad_i(pb), .gap_i(pg),
    .busy_o(busy), .ev_o(ev));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // one classic cycle; the wait is cut only by the cycle ceiling
  task wb(input [11:0] a, input w, input [31:0] x);
    q.push_back(x);
    {cyc, stb, we, adr} <= {2'b11, w, a};
    wdat <= $random(seed);
    sel  <= 4'($random(seed));
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task rd(input [9:0] i, input [31:0] x);
    wb({i, 2'b00}, 1'b0, x);
  endtask
  task burst(input [16:0] n, input [2:0] c, input b, input [1:0] g);
    {pn, pc, pb, pg, go} <= {n, c, b, g, 1'b1};
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy) @(posedge clk_i);
  endtask
  // both triggers, then all six bytes of the fresh snapshot
  task snap(input [15:0] l, u, t, input [31:0] fl, fu);
    rd(dfs_pkg::IDX_LOWER_TRIGGER, fl);
    rd(dfs_pkg::IDX_UPPER_TRIGGER, fu);
    rd(dfs_pkg::IDX_UPPER_RX_HI, 32'(u[15:8]));
    rd(dfs_pkg::IDX_UPPER_RX_LO, 32'(u[7:0]));
    rd(dfs_pkg::IDX_LOWER_RX_HI, 32'(l[15:8]));
    rd(dfs_pkg::IDX_LOWER_RX_LO, 32'(l[7:0]));
    rd(dfs_pkg::IDX_UPPER_TX_HI, 32'(t[15:8]));
    rd(dfs_pkg::IDX_UPPER_TX_LO, 32'(t[7:0]));
  endtask
  // reset held for five edges; the first request follows the edge after release
  task reset_dut();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read data is compared in the ack cycle against the oldest note
  always @(posedge clk_i)
  begin
    cycles++;
    if (ack === 1'b1)
    begin
      e = q.pop_front();
      n_tests++;
      if (rdat !== e)
      begin
        err_count++;
        $display("MISMATCH t=%0t got %h exp %h", $time, rdat, e);
      end
    end
    if (cycles == 80000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    {cyc, stb, we, go, pb, adr, sel, wdat, pn, pc, pg} <= '0;
    reset_dut();
    for (int i = 0; i < 6; i++) rd(dfs_pkg::IDX_UPPER_RX_HI + 10'(i), 32'h0);
    rd(10'h3ff, 32'h0);
    $display("test reset values done");
    burst(17'd5, 3'h7, 1'b1, 2'($random(seed)));
    rd(dfs_pkg::IDX_LOWER_RX_LO, 32'h0);
    wb({dfs_pkg::IDX_LOWER_TRIGGER, 2'b00}, 1'b1, 32'h0);
    wb({dfs_pkg::IDX_UPPER_TX_LO, 2'b00}, 1'b1, 32'h0);
    snap(16'd5, 16'd5, 16'd5, 32'h0, 32'h0);
    snap(16'd0, 16'd0, 16'd0, 32'h0, 32'h0);
    $display("test counting and clear done");
    // a sent frame in the clearing cycle stays in the fresh count as one
    fork
      burst(17'd1, 3'h4, 1'b0, 2'h0);
      begin
        @(posedge clk_i);
        rd(dfs_pkg::IDX_UPPER_TRIGGER, 32'h0);
      end
    join
    snap(16'd0, 16'd0, 16'd1, 32'h0, 32'h0);
    $display("test frame during clear done");
    burst(17'h10001, 3'h7, 1'b0, 2'h0);
    snap(16'hffff, 16'hffff, 16'hffff, 32'h1, 32'h3);
    $display("test saturation done");
    // reset in mid-run drops both live counts and a loaded snapshot
    burst(17'd3, 3'h7, 1'b0, 2'h1);
    rd(dfs_pkg::IDX_LOWER_TRIGGER, 32'h0);
    reset_dut();
    rd(dfs_pkg::IDX_LOWER_RX_LO, 32'h0);
    snap(16'd0, 16'd0, 16'd0, 32'h0, 32'h0);
    $display("test reset in mid-run done");
    conclude();
  end
endmodule
